// ### shared/charger_smbus_pkg.sv
// Constants shared by the charger SMBus target port and its register store
package charger_smbus_pkg;

  // Target address, upper seven bits of the address byte
  localparam logic [6:0]  TARGET_ADDR       = 7'h09;
  localparam logic        DIR_WRITE         = 1'b0;
  localparam logic        DIR_READ          = 1'b1;
  localparam logic        ACK_LEVEL         = 1'b0;

  localparam int          BYTE_BITS         = 8;
  localparam logic [3:0]  ACK_SLOT          = 4'h8;

  // Byte positions within a transaction
  localparam logic [1:0]  IDX_ADDR          = 2'h0;
  localparam logic [1:0]  IDX_CMD           = 2'h1;
  localparam logic [1:0]  IDX_LOW           = 2'h2;
  localparam logic [1:0]  IDX_HIGH          = 2'h3;

  // Command codes
  localparam logic [7:0]  CMD_SETTINGS_CTRL = 8'h12;
  localparam logic [7:0]  CMD_FAST_CURRENT  = 8'h14;
  localparam logic [7:0]  CMD_BATT_VOLTAGE  = 8'h15;
  localparam logic [7:0]  CMD_ADAPTER_LIMIT = 8'h3F;
  localparam logic [7:0]  CMD_MAKER_CODE    = 8'hFE;
  localparam logic [7:0]  CMD_PART_CODE     = 8'hFF;

  // Power-on values
  localparam logic [15:0] RST_SETTINGS_CTRL = 16'h7904;
  localparam logic [15:0] RST_FAST_CURRENT  = 16'h0000;
  localparam logic [15:0] RST_BATT_VOLTAGE  = 16'h0000;
  localparam logic [15:0] RST_ADAPTER_LIMIT = 16'h1000;

  // Implemented bits of each setting word
  localparam logic [15:0] MASK_SETTINGS     = 16'hFFFF;
  localparam logic [15:0] MASK_FAST_CURRENT = 16'h1FC0;
  localparam logic [15:0] MASK_BATT_VOLTAGE = 16'h7FF0;
  localparam logic [15:0] MASK_ADAPTER_LIM  = 16'h1F80;
  localparam logic [15:0] MASK_NONE         = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_ADDR    = 3'b001,
    ST_RX      = 3'b010,
    ST_ACK_OUT = 3'b011,
    ST_TX      = 3'b100,
    ST_HOST_AK = 3'b101,
    ST_WAIT    = 3'b110
  } link_state_e;

  // Writable bits for a command; zero for read-only or undecoded codes
  function automatic logic [15:0] write_mask(input logic [7:0] cmd);
    logic [15:0] m;
    m = MASK_NONE;
    if (cmd == CMD_SETTINGS_CTRL)
      m = MASK_SETTINGS;
    else if (cmd == CMD_FAST_CURRENT)
      m = MASK_FAST_CURRENT;
    else if (cmd == CMD_BATT_VOLTAGE)
      m = MASK_BATT_VOLTAGE;
    else if (cmd == CMD_ADAPTER_LIMIT)
      m = MASK_ADAPTER_LIM;
    return m;
  endfunction

endpackage

// ### src/smbus_reg_store.sv
// Command register store with registered read port
`timescale 1ns/1ps
`default_nettype none
module smbus_reg_store
  import charger_smbus_pkg::*;
#(
  // Arbitrary identification values
  parameter logic [15:0] MAKER_CODE = 16'h00A5,
  parameter logic [15:0] PART_CODE  = 16'h005A
)(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        wr_en,
  input  wire logic [7:0]  wr_cmd,
  input  wire logic [15:0] wr_data,
  input  wire logic [7:0]  rd_cmd,
  output logic      [15:0] rd_data,
  output logic      [15:0] settings_q,
  output logic      [15:0] current_q,
  output logic      [15:0] voltage_q,
  output logic      [15:0] adapter_q
);

  logic [15:0] wmask;

  assign wmask = write_mask(wr_cmd);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      settings_q <= RST_SETTINGS_CTRL;
      current_q  <= RST_FAST_CURRENT;
      voltage_q  <= RST_BATT_VOLTAGE;
      adapter_q  <= RST_ADAPTER_LIMIT;
    end
    else if (wr_en && wmask != MASK_NONE)
    begin
      if (wr_cmd == CMD_SETTINGS_CTRL)
        settings_q <= wr_data & wmask;
      else if (wr_cmd == CMD_FAST_CURRENT)
        current_q <= wr_data & wmask;
      else if (wr_cmd == CMD_BATT_VOLTAGE)
        voltage_q <= wr_data & wmask;
      else
        adapter_q <= wr_data & wmask;
    end
  end

  // Registered read; unknown codes read as zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_data <= 16'h0000;
    else if (rd_cmd == CMD_SETTINGS_CTRL)
      rd_data <= settings_q;
    else if (rd_cmd == CMD_FAST_CURRENT)
      rd_data <= current_q;
    else if (rd_cmd == CMD_BATT_VOLTAGE)
      rd_data <= voltage_q;
    else if (rd_cmd == CMD_ADAPTER_LIMIT)
      rd_data <= adapter_q;
    else if (rd_cmd == CMD_MAKER_CODE)
      rd_data <= MAKER_CODE;
    else if (rd_cmd == CMD_PART_CODE)
      rd_data <= PART_CODE;
    else
      rd_data <= 16'h0000;
  end

endmodule
`default_nettype wire

// ### src/charger_smbus_slave_regs.sv
// SMBus target port of the charge controller with its command registers
//
// Contract
// - Target only, address byte 0x12 for writes
// - Respond only out of lockout with adapter present
// - Start: SDA falls while SCL high
// - Stop: SDA rises while SCL high, bus free
// - SDA changes only while SCL low
// - Bytes MSB first, sampled on SCL rise
// - Nine clocks per byte, ninth is acknowledge
// - Word write: address, command, low, high; all acked
// - Word read: repeated start, low acked, high nacked
// - Ack low, nack high; write low, read high
// - Settings control 0x12, read/write, resets 0x7904
// - Fast current 0x14, 7-bit field, resets zero
// - Battery voltage 0x15, 11-bit field, resets zero
// - Adapter limit 0x3F, 6-bit field, resets 0x1000
// - Maker 0xFE and part 0xFF fixed codes
`timescale 1ns/1ps
`default_nettype none
module charger_smbus_slave_regs
  import charger_smbus_pkg::*;
#(
  // Arbitrary identification values
  parameter logic [15:0] MAKER_CODE = 16'h00A5,
  parameter logic [15:0] PART_CODE  = 16'h005A
)(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        scl,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic        adapter_detect_input,
  input  wire logic        supply_undervoltage_lockout,
  output logic             port_enabled,
  output logic             bus_busy,
  output logic      [15:0] charger_settings_control,
  output logic      [15:0] fast_charge_current_limit,
  output logic      [15:0] battery_voltage_target,
  output logic      [15:0] adapter_current_limit
);

  // ------------------------------------------------------------------
  // Link domain: SCL rising edge samples SDA and flags the event
  // ------------------------------------------------------------------
  logic        link_bit_r;
  logic        link_tgl_r;

  always_ff @(posedge scl or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link_bit_r <= 1'b1;
      link_tgl_r <= 1'b0;
    end
    else
    begin
      link_bit_r <= sda_i;
      link_tgl_r <= ~link_tgl_r;
    end
  end

  // ------------------------------------------------------------------
  // System domain synchronisers
  // ------------------------------------------------------------------
  logic        scl_q1_r;
  logic        scl_q2_r;
  logic        scl_q3_r;
  logic        sda_q1_r;
  logic        sda_q2_r;
  logic        sda_q3_r;
  logic        tgl_q1_r;
  logic        tgl_q2_r;
  logic        tgl_q3_r;
  logic        acd_q1_r;
  logic        acd_q2_r;
  logic        uvl_q1_r;
  logic        uvl_q2_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_q1_r <= 1'b1;
      scl_q2_r <= 1'b1;
      scl_q3_r <= 1'b1;
      sda_q1_r <= 1'b1;
      sda_q2_r <= 1'b1;
      sda_q3_r <= 1'b1;
      tgl_q1_r <= 1'b0;
      tgl_q2_r <= 1'b0;
      tgl_q3_r <= 1'b0;
      acd_q1_r <= 1'b0;
      acd_q2_r <= 1'b0;
      uvl_q1_r <= 1'b1;
      uvl_q2_r <= 1'b1;
    end
    else
    begin
      scl_q1_r <= scl;
      scl_q2_r <= scl_q1_r;
      scl_q3_r <= scl_q2_r;
      sda_q1_r <= sda_i;
      sda_q2_r <= sda_q1_r;
      sda_q3_r <= sda_q2_r;
      tgl_q1_r <= link_tgl_r;
      tgl_q2_r <= tgl_q1_r;
      tgl_q3_r <= tgl_q2_r;
      acd_q1_r <= adapter_detect_input;
      acd_q2_r <= acd_q1_r;
      uvl_q1_r <= supply_undervoltage_lockout;
      uvl_q2_r <= uvl_q1_r;
    end
  end

  // ------------------------------------------------------------------
  // Bus events
  // ------------------------------------------------------------------
  logic        enabled;
  logic        start_ev;
  logic        stop_ev;
  logic        rise_ev;
  logic        fall_ev;
  logic        rx_bit;

  assign enabled  = acd_q2_r && !uvl_q2_r;
  assign start_ev = scl_q2_r && scl_q3_r && sda_q3_r && !sda_q2_r;
  assign stop_ev  = scl_q2_r && scl_q3_r && !sda_q3_r && sda_q2_r;
  assign fall_ev  = scl_q3_r && !scl_q2_r;
  // Sample is held in the link domain until the next SCL rise, so it is
  // stable for the whole high phase when the toggle arrives here
  assign rise_ev  = tgl_q2_r ^ tgl_q3_r;
  assign rx_bit   = link_bit_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      port_enabled <= 1'b0;
    else
      port_enabled <= enabled;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      bus_busy <= 1'b0;
    else if (!enabled)
      bus_busy <= 1'b0;
    else if (start_ev)
      bus_busy <= 1'b1;
    else if (stop_ev)
      bus_busy <= 1'b0;
  end

  // ------------------------------------------------------------------
  // Transaction engine
  // ------------------------------------------------------------------
  link_state_e state_r;
  logic [3:0]  cnt_r;
  logic [7:0]  shift_r;
  logic [1:0]  idx_r;
  logic        dir_r;
  logic        high_sent_r;
  logic [7:0]  cmd_r;
  logic [7:0]  low_r;
  logic [15:0] tx_word_r;
  logic [15:0] rd_word;
  logic        wr_en_r;
  logic [15:0] wr_data_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r     <= ST_IDLE;
      cnt_r       <= 4'h0;
      shift_r     <= 8'h00;
      idx_r       <= IDX_ADDR;
      dir_r       <= DIR_WRITE;
      high_sent_r <= 1'b0;
      cmd_r       <= 8'h00;
      low_r       <= 8'h00;
      tx_word_r   <= 16'h0000;
      sda_oe      <= 1'b0;
    end
    else if (!enabled)
    begin
      // Lockout or adapter loss drops any transfer and frees SDA
      state_r <= ST_IDLE;
      sda_oe  <= 1'b0;
    end
    else if (stop_ev)
    begin
      state_r <= ST_IDLE;
      sda_oe  <= 1'b0;
    end
    else if (start_ev)
    begin
      // Repeated start keeps the command byte for the read phase
      state_r <= ST_ADDR;
      cnt_r   <= 4'h0;
      idx_r   <= IDX_ADDR;
      sda_oe  <= 1'b0;
    end
    else if (rise_ev)
    begin
      case (state_r)
        ST_ADDR, ST_RX:
        begin
          if (cnt_r < ACK_SLOT)
          begin
            shift_r <= {shift_r[6:0], rx_bit};
            cnt_r   <= cnt_r + 4'h1;
          end
        end
        ST_TX:
          cnt_r <= cnt_r + 4'h1;
        ST_HOST_AK:
          high_sent_r <= (rx_bit == ACK_LEVEL) && !high_sent_r;
        default:
          cnt_r <= cnt_r;
      endcase
    end
    else if (fall_ev)
    begin
      // All SDA changes happen just after SCL has gone low
      case (state_r)
        ST_ADDR:
        begin
          if (cnt_r == ACK_SLOT)
          begin
            if (shift_r[7:1] == TARGET_ADDR)
            begin
              dir_r   <= shift_r[0];
              sda_oe  <= 1'b1;
              state_r <= ST_ACK_OUT;
            end
            else
              state_r <= ST_WAIT;
          end
        end
        ST_RX:
        begin
          if (cnt_r == ACK_SLOT)
          begin
            if (idx_r == IDX_CMD)
              cmd_r <= shift_r;
            else if (idx_r == IDX_LOW)
              low_r <= shift_r;
            sda_oe  <= 1'b1;
            state_r <= ST_ACK_OUT;
          end
        end
        ST_ACK_OUT:
        begin
          cnt_r <= 4'h0;
          if (idx_r == IDX_ADDR && dir_r == DIR_READ)
          begin
            tx_word_r   <= rd_word;
            high_sent_r <= 1'b0;
            sda_oe      <= ~rd_word[7];
            state_r     <= ST_TX;
          end
          else if (idx_r == IDX_HIGH)
          begin
            // Bytes past the high byte are not acknowledged
            sda_oe  <= 1'b0;
            state_r <= ST_WAIT;
          end
          else
          begin
            sda_oe  <= 1'b0;
            idx_r   <= idx_r + 2'h1;
            state_r <= ST_RX;
          end
        end
        ST_TX:
        begin
          if (cnt_r == ACK_SLOT)
          begin
            sda_oe  <= 1'b0;
            state_r <= ST_HOST_AK;
          end
          else
            sda_oe <= ~tx_word_r[3'(7 - cnt_r)];
        end
        ST_HOST_AK:
        begin
          cnt_r <= 4'h0;
          if (high_sent_r)
          begin
            tx_word_r <= {8'h00, tx_word_r[15:8]};
            sda_oe    <= ~tx_word_r[15];
            state_r   <= ST_TX;
          end
          else
          begin
            // Host nack on the high byte ends the read
            sda_oe  <= 1'b0;
            state_r <= ST_WAIT;
          end
        end
        default:
          sda_oe <= 1'b0;
      endcase
    end
  end

  // Host ack only counts after the low byte; after the high byte the flag
  // above goes low again, so a second ack still ends the transfer cleanly

  // Open-drain: only ever pull low
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sda_o <= 1'b0;
    else
      sda_o <= ACK_LEVEL;
  end

  // Commit happens once, as the high byte's acknowledge clock ends
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_en_r   <= 1'b0;
      wr_data_r <= 16'h0000;
    end
    else
    begin
      wr_en_r   <= enabled && fall_ev && !stop_ev && !start_ev && !rise_ev
                   && state_r == ST_ACK_OUT && idx_r == IDX_HIGH;
      wr_data_r <= {shift_r, low_r};
    end
  end

  smbus_reg_store #(
    .MAKER_CODE (MAKER_CODE),
    .PART_CODE  (PART_CODE)
  ) u_store (
    .clk        (clk),
    .rst_n      (rst_n),
    .wr_en      (wr_en_r),
    .wr_cmd     (cmd_r),
    .wr_data    (wr_data_r),
    .rd_cmd     (cmd_r),
    .rd_data    (rd_word),
    .settings_q (charger_settings_control),
    .current_q  (fast_charge_current_limit),
    .voltage_q  (battery_voltage_target),
    .adapter_q  (adapter_current_limit)
  );

endmodule
`default_nettype wire

// ### tb/charger_smbus_slave_regs_asserts.sv
// Assertions on the charger SMBus target port
`timescale 1ns/1ps
`default_nettype none
module charger_smbus_slave_regs_asserts
  import charger_smbus_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        scl,
  input wire logic        sda_i,
  input wire logic        sda_oe,
  input wire logic        adapter_detect_input,
  input wire logic        supply_undervoltage_lockout,
  input wire logic        port_enabled,
  input wire logic        bus_busy,
  input wire logic [15:0] charger_settings_control,
  input wire logic [15:0] fast_charge_current_limit,
  input wire logic [15:0] battery_voltage_target,
  input wire logic [15:0] adapter_current_limit
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [63:0] regs;
  assign regs = {charger_settings_control, fast_charge_current_limit,
                 battery_voltage_target, adapter_current_limit};
  sequence start_seen;
    scl && $past(scl) && $fell(sda_i);
  endsequence
  sequence stop_seen;
    scl && $past(scl) && $rose(sda_i);
  endsequence
  a_enable_tracks: assert property (
    (adapter_detect_input && !supply_undervoltage_lockout)[*5] |-> port_enabled)
    else $error("port not enabled");
  a_lockout_blocks: assert property (
    (supply_undervoltage_lockout || !adapter_detect_input)[*5] |-> !port_enabled && !sda_oe)
    else $error("port active while disqualified");
  a_start_busy: assert property ((start_seen ##0 port_enabled) |-> ##[1:4] bus_busy)
    else $error("start not seen");
  a_stop_frees: assert property (stop_seen |-> ##[1:4] !bus_busy)
    else $error("stop not seen");
  a_drive_scl_low: assert property ($rose(sda_oe) |-> !scl)
    else $error("data driven while clock high");
  a_ack_holds_high: assert property (($rose(scl) && sda_oe) |-> sda_oe[*4])
    else $error("drive dropped in high phase");
  a_idle_quiet: assert property ((!bus_busy && !$past(bus_busy)) |-> !sda_oe)
    else $error("driving on a free bus");
  a_regs_in_frame: assert property ($changed(regs) |-> bus_busy)
    else $error("register moved outside a transfer");
  a_unused_bits: assert property (
    ((fast_charge_current_limit & ~MASK_FAST_CURRENT) | (battery_voltage_target
      & ~MASK_BATT_VOLTAGE) | (adapter_current_limit & ~MASK_ADAPTER_LIM)) == 16'h0000)
    else $error("unused setting bits set");
endmodule
`default_nettype wire

// ### tb/smbus_host_model.sv
// Host side model: SMBus master doing word writes and reads
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model
  import charger_smbus_pkg::*;
#(
  parameter int HP = 210
)(
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  localparam int Q = HP / 4;
  // Clock stands high between frames
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic clk_bit(input logic b, output logic s);
    #(Q) sda_low = !b;
    #(HP - Q) scl = 1'b1;
    #(HP) s = sda;
    scl = 1'b0;
  endtask
  task automatic start_cond();
    #(Q) sda_low = 1'b0;
    #(HP - Q) scl = 1'b1;
    #(HP) sda_low = 1'b1;
    #(HP) scl = 1'b0;
  endtask
  task automatic stop_cond();
    #(Q) sda_low = 1'b1;
    #(HP - Q) scl = 1'b1;
    #(HP) sda_low = 1'b0;
    #(HP);
  endtask
  task automatic xfer_byte(input logic [7:0] tx, input logic ack_in,
                           output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--)
      clk_bit(tx[i], rx[i]);
    clk_bit(ack_in, ack);
  endtask
  // Acknowledge bits come back low for ack, one per byte
  task automatic write_word(input logic [7:0] adr, input logic [7:0] cmd,
                            input logic [15:0] d, output logic [3:0] nak);
    logic [7:0] rx;
    start_cond();
    xfer_byte(adr, 1'b1, rx, nak[3]);
    xfer_byte(cmd, 1'b1, rx, nak[2]);
    xfer_byte(d[7:0], 1'b1, rx, nak[1]);
    xfer_byte(d[15:8], 1'b1, rx, nak[0]);
    stop_cond();
  endtask
  task automatic read_word(input logic [7:0] cmd, output logic [15:0] d,
                           output logic [2:0] nak);
    logic [7:0] rx;
    logic       x;
    start_cond();
    xfer_byte({TARGET_ADDR, DIR_WRITE}, 1'b1, rx, nak[2]);
    xfer_byte(cmd, 1'b1, rx, nak[1]);
    start_cond();
    xfer_byte({TARGET_ADDR, DIR_READ}, 1'b1, rx, nak[0]);
    xfer_byte(8'hFF, 1'b0, d[7:0], x);
    xfer_byte(8'hFF, 1'b1, d[15:8], x);
    stop_cond();
  endtask
endmodule
`default_nettype wire

// ### tb/charger_smbus_slave_regs_bench.sv
// Bench for the charger SMBus target port
`timescale 1ns/1ps
`default_nettype none
module charger_smbus_slave_regs_bench
  import charger_smbus_pkg::*;
;
  localparam logic [15:0] MAKER = 16'h00C3; // Arbitrary value
  localparam logic [15:0] PART  = 16'h003C; // Arbitrary value
  logic        clk, rst_n, adapter, lockout, scl, host_low, sda_oe, sda_o, sda_i;
  logic        port_on, busy;
  logic [63:0] regs_cat, exp_cat;
  logic [15:0] settings, current, voltage, adapter_lim;
  int          failures = 0;
  int          checks_done = 0;
  int          cycles = 0;
  logic [7:0]  cmds [6] = '{CMD_SETTINGS_CTRL, CMD_FAST_CURRENT, CMD_BATT_VOLTAGE,
                            CMD_ADAPTER_LIMIT, CMD_MAKER_CODE, CMD_PART_CODE};
  logic [15:0] rsts [6] = '{RST_SETTINGS_CTRL, RST_FAST_CURRENT, RST_BATT_VOLTAGE,
                            RST_ADAPTER_LIMIT, MAKER, PART};
  logic [15:0] masks [4] = '{MASK_SETTINGS, MASK_FAST_CURRENT, MASK_BATT_VOLTAGE,
                             MASK_ADAPTER_LIM};
  // Refused writes: address byte, command, {adapter, lockout}, expected acks
  logic [7:0]  r_adr [4] = '{8'h12, 8'h14, 8'h12, 8'h12};
  logic [7:0]  r_cmd [4] = '{8'h20, 8'h12, 8'h12, 8'h12};
  logic [1:0]  r_pwr [4] = '{2'h2, 2'h2, 2'h3, 2'h0};
  logic [3:0]  r_nak [4] = '{4'h0, 4'hF, 4'hF, 4'hF};
  // Open drain with pull-up: low if either side pulls
  assign sda_i = !((sda_oe && !sda_o) || host_low);
  assign regs_cat = {settings, current, voltage, adapter_lim};
  charger_smbus_slave_regs #(.MAKER_CODE(MAKER), .PART_CODE(PART)) uut (
    .clk(clk), .rst_n(rst_n), .scl(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .adapter_detect_input(adapter), .supply_undervoltage_lockout(lockout),
    .port_enabled(port_on), .bus_busy(busy), .charger_settings_control(settings),
    .fast_charge_current_limit(current), .battery_voltage_target(voltage),
    .adapter_current_limit(adapter_lim));
  smbus_host_model host (.scl(scl), .sda_low(host_low), .sda(sda_i));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Ceiling well above some 35 transfers of under 900 cycles each
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 80000)
    begin
      failures++;
      test_done();
    end
  end
  initial
  begin
    logic [15:0] d;
    logic [15:0] pat;
    logic [3:0]  nw;
    logic [2:0]  nr;
    rst_n = 1'b0;
    adapter = 1'b1;
    lockout = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    for (int i = 0; i < 6; i++)
    begin
      host.read_word(cmds[i], d, nr);
      check(d, rsts[i]);
      check({13'h0000, nr}, 16'h0000);
    end
    check({15'h0000, port_on}, 16'h0001);
    check({15'h0000, busy}, 16'h0000);
    $display("test power-on values done");
    // Two patterns: all ones sets every stored bit, then 0x5AA5 clears its zero bits
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 6; i++)
      begin
        pat = (p == 0) ? 16'hFFFF : 16'h5AA5;
        host.write_word({TARGET_ADDR, DIR_WRITE}, cmds[i], pat, nw);
        check({12'h000, nw}, 16'h0000);
        host.read_word(cmds[i], d, nr);
        check(d, (i < 4) ? (pat & masks[i]) : rsts[i]);
        if (i < 4)
          exp_cat[16*(3-i) +: 16] = pat & masks[i];
      end
    for (int j = 0; j < 4; j++)
      check(regs_cat[16*j +: 16], exp_cat[16*j +: 16]);
    $display("test write and read back done");
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk);
      {adapter, lockout} <= r_pwr[k];
      repeat (8) @(posedge clk);
      host.write_word(r_adr[k], r_cmd[k], 16'h0000, nw);
      check({12'h000, nw}, {12'h000, r_nak[k]});
      check({15'h0000, port_on}, {15'h0000, r_pwr[k] == 2'h2});
      check({15'h0000, busy}, 16'h0000);
      for (int j = 0; j < 4; j++)
        check(regs_cat[16*j +: 16], exp_cat[16*j +: 16]);
    end
    $display("test refused writes done");
    // Mid-run reset must bring back every power-on value
    @(posedge clk);
    {adapter, lockout} <= 2'h2;
    repeat (8) @(posedge clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    for (int j = 0; j < 4; j++)
      check(regs_cat[16*j +: 16], rsts[3-j]);
    check({15'h0000, port_on}, 16'h0001);
    check({15'h0000, busy}, 16'h0000);
    host.read_word(CMD_SETTINGS_CTRL, d, nr);
    check(d, RST_SETTINGS_CTRL);
    check({13'h0000, nr}, 16'h0000);
    $display("test reset values done");
    test_done();
  end
endmodule
bind charger_smbus_slave_regs charger_smbus_slave_regs_asserts chk (
  .clk(clk), .rst_n(rst_n), .scl(scl), .sda_i(sda_i), .sda_oe(sda_oe),
  .adapter_detect_input(adapter_detect_input),
  .supply_undervoltage_lockout(supply_undervoltage_lockout),
  .port_enabled(port_enabled), .bus_busy(bus_busy),
  .charger_settings_control(charger_settings_control),
  .fast_charge_current_limit(fast_charge_current_limit),
  .battery_voltage_target(battery_voltage_target),
  .adapter_current_limit(adapter_current_limit));
`default_nettype wire
